// ---- dsq_seq.sv ----
// Delta-sigma conversion sequencer with sinc4 decimator and result buffer
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE_01: Four modes: single, multi, continuous, turbo.
// RULE_02: Start bit or hardware trigger begins conversion.
// RULE_03: Completion sets flag; output high until read.
// RULE_04: Single mode idles in standby until triggered.
// RULE_05: Single trigger: four conversions, fourth valid.
// RULE_06: After transfer, single returns to standby.
// RULE_07: Continuous: first result after three priming periods.
// RULE_08: Software must not switch inputs in continuous.
// RULE_09: Multi mode clears and reprimes filter per sample.
// RULE_10: Multi mode starts next sample automatically.
// RULE_11: After input switch, data invalid until fourth.
// RULE_12: 12-bit at 192 ksps, 8-bit at 384 ksps.
// RULE_13: Decimator sets resolution and sample rate.
// RULE_14: Decimator turns bitstream into parallel words.
// RULE_15: Four-stage sinc decimation filter.
// RULE_16: Software polls flag or uses completion output.
// RULE_17: Reset: standby, flags clear, result held; the code clears the result to zero.
module dsq_seq
	import dsq_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [1:0] mode_i,
	input wire logic res8_i,
	input wire logic start_i,
	input wire logic stop_i,
	input wire logic trig_i,
	input wire logic mod_bit_i,
	input wire logic mux_switch_i,
	input wire logic rd_i,
	input wire logic clr_done_i,
	output logic [RES_W-1:0] result_o,
	output logic eoc_o,
	output logic done_o,
	output logic standby_o
);

	// Whole sequencer state
	typedef struct packed {
		dsq_state_t state; // Sequencer state
		dsq_mode_t mode; // Mode caught at start
		logic fast; // 8-bit fast decimation in use
		logic standby; // Standby indication
		logic [PH_W-1:0] phase; // Clock within conversion
		logic [2:0] cnt; // Conversions since priming began
		logic [ACC_W-1:0] i1; // Integrator stages
		logic [ACC_W-1:0] i2;
		logic [ACC_W-1:0] i3;
		logic [ACC_W-1:0] i4;
		logic [ACC_W-1:0] d1; // Comb delays
		logic [ACC_W-1:0] d2;
		logic [ACC_W-1:0] d3;
		logic [ACC_W-1:0] d4;
		logic trig_s1; // Trigger pin synchroniser
		logic trig_s2;
		logic trig_s3; // Previous level, for the edge
		logic mod_s1; // Bitstream pin synchroniser
		logic mod_s2;
		logic [RES_W-1:0] oreg; // Result seen by the reader
		logic ofull; // Result waiting to be read
		logic done; // Sticky completion flag
		logic [7:0] since; // Run clocks since start
	} dsq_st_t;

	dsq_st_t s;
	dsq_st_t next_s;
	dsq_fifo_if fif ();

	logic trig_rise; // Synchronised trigger edge
	logic go; // Start request of either kind
	logic [PH_W-1:0] last; // Last phase of this conversion
	logic conv_end; // Conversion period ends now
	logic emit; // This conversion yields a result
	logic adv; // Filter may advance this cycle
	logic take; // Output register loads from buffer
	logic [ACC_W-1:0] c1; // Comb outputs
	logic [ACC_W-1:0] c2;
	logic [ACC_W-1:0] c3;
	logic [ACC_W-1:0] c4;
	logic [ACC_W-1:0] scaled; // Filter output after shift
	logic [RES_W-1:0] sample; // Clamped result word

	// Result buffer between filter and reader
	dsq_fifo #(
		.W(RES_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.f(fif.fifo)
	);

	// Trigger and start decode
	assign trig_rise = s.trig_s2 && !s.trig_s3;
	assign go = start_i || trig_rise; // RULE_02

	// Conversion length picks the output rate
	assign last = s.fast ? LAST_LO : LAST_HI; // RULE_12 RULE_13
	assign conv_end = (s.phase == last);
	assign emit = conv_end && (s.cnt >= PRIME_N); // RULE_05 RULE_07 RULE_11

	// A full buffer freezes the filter rather than losing a result
	assign adv = !(emit && !fif.in_ready);

	// Comb section runs on the decimated value
	always_comb begin
		c1 = s.i4 - s.d1; // RULE_15
		c2 = c1 - s.d2;
		c3 = c2 - s.d3;
		c4 = c3 - s.d4;
		scaled = s.fast ? (c4 >> SH_LO) : (c4 >> SH_HI); // RULE_13
		if (s.fast) begin
			sample = (scaled > ACC_W'(MAX_LO)) ? MAX_LO : scaled[RES_W-1:0];
		end else begin
			sample = (scaled > ACC_W'(MAX_HI)) ? MAX_HI : scaled[RES_W-1:0];
		end
	end

	// Buffer fill and drain handshakes
	assign fif.in_valid = (s.state == ST_CONV) && emit && !stop_i; // RULE_14
	assign fif.in_data = sample;
	assign fif.out_ready = !s.ofull || rd_i;
	assign take = fif.out_valid && fif.out_ready;

	// Next state of the whole sequencer
	always_comb begin
		next_s = s;
		// Two flops before any logic reads the pins
		next_s.trig_s1 = trig_i;
		next_s.trig_s2 = s.trig_s1;
		next_s.trig_s3 = s.trig_s2;
		next_s.mod_s1 = mod_bit_i;
		next_s.mod_s2 = s.mod_s1;

		case (s.state)
			ST_IDLE: begin
				// Standby until a start request
				next_s.standby = 1'b1; // RULE_04
				if (go) begin // RULE_02
					next_s.state = ST_CONV;
					next_s.standby = 1'b0;
					next_s.mode = dsq_mode_t'(mode_i); // RULE_01
					next_s.fast = res8_i || (mode_i == MODE_TURBO);
					next_s.phase = '0;
					next_s.cnt = '0;
					next_s.since = '0;
					next_s.i1 = '0;
					next_s.i2 = '0;
					next_s.i3 = '0;
					next_s.i4 = '0;
					next_s.d1 = '0;
					next_s.d2 = '0;
					next_s.d3 = '0;
					next_s.d4 = '0;
				end
			end
			ST_CONV: begin
				if (stop_i) begin
					// Abort, keep the last result
					next_s.state = ST_IDLE;
					next_s.standby = 1'b1;
				end else if (adv) begin
					// Integrators run at the bitstream rate
					next_s.i1 = s.i1 + ACC_W'(s.mod_s2); // RULE_14 RULE_15
					next_s.i2 = s.i2 + s.i1;
					next_s.i3 = s.i3 + s.i2;
					next_s.i4 = s.i4 + s.i3;
					next_s.phase = conv_end ? '0 : s.phase + 1'b1;
					if (s.since != 8'hFF) begin
						next_s.since = s.since + 8'h01;
					end
					if (conv_end) begin
						// Decimate: update comb delays
						next_s.d1 = s.i4;
						next_s.d2 = c1;
						next_s.d3 = c2;
						next_s.d4 = c3;
						if (s.cnt != CNT_SAT) begin
							next_s.cnt = s.cnt + 3'h1;
						end
					end
					if (emit) begin
						case (s.mode)
							MODE_SINGLE: begin
								next_s.state = ST_HOLD; // RULE_05
							end
							MODE_MULTI, MODE_TURBO: begin
								// Fresh filter, next sample at once
								next_s.cnt = '0; // RULE_09 RULE_10
								next_s.phase = '0;
								next_s.i1 = '0;
								next_s.i2 = '0;
								next_s.i3 = '0;
								next_s.i4 = '0;
								next_s.d1 = '0;
								next_s.d2 = '0;
								next_s.d3 = '0;
								next_s.d4 = '0;
							end
							default: begin
								// Continuous keeps the filter primed
								next_s.state = ST_CONV; // RULE_07
							end
						endcase
					end
				end
				// Input switched: restart priming count
				if (mux_switch_i && !stop_i) begin
					next_s.cnt = '0; // RULE_11
				end
			end
			ST_HOLD: begin
				// Back to standby once the last result is read
				if (rd_i && s.ofull && !fif.out_valid) begin
					next_s.state = ST_IDLE; // RULE_06
					next_s.standby = 1'b1;
				end
			end
			default: begin
				next_s.state = ST_IDLE;
				next_s.standby = 1'b1;
			end
		endcase

		// Reader side: loading wins over a read in the same cycle
		if (take) begin
			next_s.oreg = fif.out_data; // RULE_17
			next_s.ofull = 1'b1; // RULE_03
		end else if (rd_i) begin
			next_s.ofull = 1'b0; // RULE_03
		end
		// Sticky flag: a new completion beats a clear
		if (take) begin
			next_s.done = 1'b1; // RULE_16
		end else if (clr_done_i) begin
			next_s.done = 1'b0;
		end
	end

	// State register; reset lands in standby
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s <= '0; // RULE_17
			s.standby <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Outputs come straight from the state register
	assign result_o = s.oreg;
	assign eoc_o = s.ofull; // RULE_03 RULE_16
	assign done_o = s.done;
	assign standby_o = s.standby;

	// Checks
	localparam int LAT_HI = 4 * DEC_HI - 1;
	localparam int LAT_LO = 4 * DEC_LO - 1;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	// Completion output holds until a read
	property p_eoc_hold;
		eoc_o && !rd_i |=> eoc_o;
	endproperty
	a_eoc_hold: assert property (p_eoc_hold) else $error("eoc dropped unread"); // RULE_03

	// A result entering the buffer shows up on eoc within two cycles
	property p_eoc_rise;
		fif.in_valid && fif.in_ready && !eoc_o |-> ##[1:2] eoc_o;
	endproperty
	a_eoc_rise: assert property (p_eoc_rise) else $error("eoc did not rise"); // RULE_03

	// Standby holds without a start request
	property p_standby;
		standby_o && s.state == ST_IDLE && !go |=> standby_o;
	endproperty
	a_standby: assert property (p_standby) else $error("left standby unasked"); // RULE_04

	// A start request leaves standby next cycle
	property p_start;
		s.state == ST_IDLE && go |=> !standby_o && s.state == ST_CONV;
	endproperty
	a_start: assert property (p_start) else $error("start ignored"); // RULE_02

	// Single result never earlier than four conversion periods
	property p_single_four;
		fif.in_valid && s.mode == MODE_SINGLE
			|-> s.since >= 8'(s.fast ? LAT_LO : LAT_HI);
	endproperty
	a_single_four: assert property (p_single_four) else $error("single too early"); // RULE_05

	// After the final read single mode is back in standby
	property p_single_back;
		s.state == ST_HOLD && rd_i && s.ofull && !fif.out_valid
			|=> standby_o && s.state == ST_IDLE;
	endproperty
	a_single_back: assert property (p_single_back) else $error("no standby"); // RULE_06

	// Multi mode restarts a fresh sample on its own
	property p_multi_next;
		fif.in_valid && fif.in_ready
			&& (s.mode == MODE_MULTI || s.mode == MODE_TURBO)
			|=> s.state == ST_CONV && s.cnt == 3'h0 && s.i4 == '0;
	endproperty
	a_multi_next: assert property (p_multi_next) else $error("multi not reprimed"); // RULE_09

	// Switching the input restarts priming
	property p_mux;
		s.state == ST_CONV && mux_switch_i && !stop_i |=> s.cnt == 3'h0;
	endproperty
	a_mux: assert property (p_mux) else $error("switch not seen"); // RULE_11

	// No result before three priming conversions
	property p_primed;
		fif.in_valid |-> s.cnt >= PRIME_N && conv_end;
	endproperty
	a_primed: assert property (p_primed) else $error("unprimed result"); // RULE_07

	// Fast resolution never sets the upper result bits
	property p_res;
		fif.in_valid && s.fast |-> fif.in_data <= MAX_LO;
	endproperty
	a_res: assert property (p_res) else $error("8-bit result too wide"); // RULE_12

	// Main scenarios
	c_single: cover property (s.state == ST_HOLD && rd_i && s.ofull);
	c_multi: cover property (fif.in_valid && s.mode == MODE_MULTI);
	c_cont: cover property (fif.in_valid && s.mode == MODE_CONT);
	c_full: cover property (fif.in_valid && !fif.in_ready);

endmodule : dsq_seq

`default_nettype wire

// ---- dsq_pkg.sv ----
// Shared constants and types for the delta-sigma conversion sequencer
package dsq_pkg;

	// Converter clock
	localparam int CLK_HZ = 10_000_000;
	localparam int CLK_PERIOD_NS = 100;

	// Output rates at the two resolutions, samples per second
	localparam int SPS_HI = 192_000;
	localparam int SPS_LO = 384_000;

	// Clocks per conversion; fastest rate, so the period rounds up
	localparam int DEC_HI = (CLK_HZ + SPS_HI - 1) / SPS_HI;
	localparam int DEC_LO = (CLK_HZ + SPS_LO - 1) / SPS_LO;

	// Phase counter width and last phase of each conversion
	localparam int PH_W = 6;
	localparam logic [PH_W-1:0] LAST_HI = PH_W'(DEC_HI - 1);
	localparam logic [PH_W-1:0] LAST_LO = PH_W'(DEC_LO - 1);

	// Sinc4 accumulator width: holds DEC_HI**4 without loss
	localparam int ACC_W = 23;

	// Result width and scaling of the filter output
	localparam int RES_W = 12;
	localparam int SH_HI = 11;
	localparam int SH_LO = 11;
	localparam logic [RES_W-1:0] MAX_HI = 12'hFFF;
	localparam logic [RES_W-1:0] MAX_LO = 12'h0FF;

	// Conversions that only prime the filter before a valid one
	localparam logic [2:0] PRIME_N = 3'h3;
	localparam logic [2:0] CNT_SAT = 3'h4;

	// Result buffer depth
	localparam int FIFO_DEPTH = 8;

	// Operating modes as selected on mode_i
	typedef enum logic [1:0] {
		MODE_SINGLE = 2'h0,
		MODE_MULTI = 2'h1,
		MODE_CONT = 2'h2,
		MODE_TURBO = 2'h3
	} dsq_mode_t;

	// Sequencer states, Gray along standby, run, hold
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_CONV = 2'h1,
		ST_HOLD = 2'h3
	} dsq_state_t;

endpackage : dsq_pkg

// ---- dsq_fifo_if.sv ----
// Handshake bundle between the sequencer and its result buffer
`timescale 1ns/1ps
`default_nettype none

interface dsq_fifo_if;
	logic in_valid; // Sequencer offers a result
	logic in_ready; // Buffer has room
	logic [dsq_pkg::RES_W-1:0] in_data; // Offered result
	logic out_valid; // Buffer holds a result
	logic out_ready; // Sequencer takes the head
	logic [dsq_pkg::RES_W-1:0] out_data; // Head of the buffer

	// Sequencer end: fills and drains
	modport user (
		output in_valid, in_data, out_ready,
		input in_ready, out_valid, out_data
	);

	// Buffer end
	modport fifo (
		input in_valid, in_data, out_ready,
		output in_ready, out_valid, out_data
	);
endinterface : dsq_fifo_if

`default_nettype wire

// ---- dsq_fifo.sv ----
// Result buffer: flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module dsq_fifo
	import dsq_pkg::*;
#(
	parameter int W = RES_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	dsq_fifo_if.fifo f
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	// Whole buffer state
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem; // Storage words
		logic [AW-1:0] wr; // Write index
		logic [AW-1:0] rd; // Read index
		logic [CW-1:0] cnt; // Words held
	} dsq_fifo_st_t;

	dsq_fifo_st_t s;
	dsq_fifo_st_t next_s;
	logic push; // Word enters this cycle
	logic pop; // Word leaves this cycle

	// Honest flags straight from the count
	assign f.in_ready = (s.cnt != CW'(DEPTH));
	assign f.out_valid = (s.cnt != '0);
	assign f.out_data = s.mem[s.rd];
	assign push = f.in_valid && f.in_ready;
	assign pop = f.out_valid && f.out_ready;

	// Next state of pointers, count and storage
	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wr] = f.in_data;
			next_s.wr = s.wr + 1'b1;
		end
		if (pop) begin
			next_s.rd = s.rd + 1'b1;
		end
		if (push && !pop) begin
			next_s.cnt = s.cnt + 1'b1;
		end else if (pop && !push) begin
			next_s.cnt = s.cnt - 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule : dsq_fifo

`default_nettype wire

// ---- dsq_host.sv ----
// Reader model: the CPU or DMA side that takes finished results
`timescale 1ns/1ps
`default_nettype none

module dsq_host
	import dsq_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic eoc_i,
	input wire logic [RES_W-1:0] result_i,
	input wire logic hold_i,
	input wire logic [3:0] wait_i,
	output logic rd_o,
	output logic took_o,
	output logic [RES_W-1:0] word_o
);
	int cnt; // Cycles the pending result has waited

	// Read request, changed just after the falling edge
	always @(negedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rd_o <= 1'b0;
			cnt <= 0;
		end else if (hold_i) begin
			rd_o <= 1'b0; // Stalled, lets the buffer fill
		end else if (wait_i == 4'h0) begin
			rd_o <= eoc_i;
		end else if (rd_o) begin
			rd_o <= 1'b0; // Read was taken at the last edge
			cnt <= 0;
		end else if (eoc_i) begin
			rd_o <= (cnt >= wait_i);
			cnt <= cnt + 1;
		end
	end

	// Word taken at the edge where read meets a pending result
	always @(posedge clk_i) begin
		took_o <= rd_o && eoc_i;
		word_o <= result_i;
	end
endmodule : dsq_host

`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none

module testbench
	import dsq_pkg::*;
;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0; // Low for the first cycles
	logic [1:0] mode_i = 2'h0;
	logic res8_i = 1'b0;
	logic start_i = 1'b0;
	logic stop_i = 1'b0;
	logic trig_i = 1'b0;
	logic mod_bit_i = 1'b0; // Constant per run, so results are known
	logic mux_sw = 1'b0;
	logic clr_done = 1'b0;
	logic rd_i;
	logic [RES_W-1:0] result_o;
	logic eoc_o;
	logic done_o;
	logic standby_o;
	logic hold = 1'b0; // Reader stall
	logic [3:0] wt = 4'h0; // Reader delay, zero reads back to back
	logic took;
	logic [RES_W-1:0] word;
	logic [RES_W-1:0] exp_word = 12'h000; // Model's result
	logic eoc_q = 1'b0;
	logic [31:0] seed = 32'h2EF5C87A;
	int n_mismatch = 0;
	int checked = 0;
	int cyc = 0; // Rising edges so far
	int n_took = 0;
	int t0; // Edge that took the start
	int rises[$]; // Edges at which the completion output rose
	dsq_mode_t ml[3] = '{MODE_MULTI, MODE_TURBO, MODE_CONT};

	// Clock, 100 ns period
	always #50 clk_i = ~clk_i;

	dsq_seq u_dsq_seq (.clk_i(clk_i), .resetn_i(resetn_i), .mode_i(mode_i),
		.res8_i(res8_i), .start_i(start_i), .stop_i(stop_i), .trig_i(trig_i),
		.mod_bit_i(mod_bit_i), .mux_switch_i(mux_sw), .rd_i(rd_i),
		.clr_done_i(clr_done), .result_o(result_o), .eoc_o(eoc_o),
		.done_o(done_o), .standby_o(standby_o));

	dsq_host u_dsq_host (.clk_i(clk_i), .resetn_i(resetn_i), .eoc_i(eoc_o),
		.result_i(result_o), .hold_i(hold), .wait_i(wt), .rd_o(rd_i),
		.took_o(took), .word_o(word));

	// Xorshift source for delays
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// Full-scale or zero input through sinc4, scaled and clamped
	function automatic int exp_val(input int n, input logic b);
		int v;
		v = b ? (n * n * n * n) >>> 11 : 0;
		if (n == DEC_LO && v > 255) v = 255;
		if (v > 4095) v = 4095;
		return v;
	endfunction : exp_val

	task automatic err(input string m);
		$display("Error at %0t ns: %s", $time, m);
		n_mismatch++;
	endtask : err

	task automatic cmpv(input logic [RES_W-1:0] g, input logic [RES_W-1:0] e,
			input string m);
		checked++;
		if (g !== e) err(m);
	endtask : cmpv

	task automatic cmpi(input int g, input int e, input string m);
		checked++;
		if (g != e) err(m);
	endtask : cmpi

	task automatic test_done();
		if (n_mismatch == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done

	// Edge count and completion timing, word check at every read
	always @(posedge clk_i) cyc <= cyc + 1;
	always @(negedge clk_i) begin
		if (eoc_o === 1'b1 && eoc_q !== 1'b1) rises.push_back(cyc);
		eoc_q <= eoc_o;
		if (took === 1'b1) begin
			n_took++;
			cmpv(word, exp_word, "result word");
		end
	end

	// Bounded wait for k completions
	task automatic wait_rises(input int k, input int lim);
		int i;
		i = 0;
		while (rises.size() < k) begin
			@(negedge clk_i);
			i++;
			if (i > lim) begin
				err("no result");
				test_done();
			end
		end
	endtask : wait_rises

	// Start by start bit or trigger pin
	task automatic go(input logic [1:0] m, input logic r8, input logic b,
			input logic hw, input int n);
		int ts;
		int i;
		mode_i = m;
		res8_i = r8;
		mod_bit_i = b;
		exp_word = RES_W'(exp_val(n, b));
		repeat (4) @(negedge clk_i);
		rises.delete();
		trig_i = hw;
		start_i = !hw;
		ts = cyc;
		@(negedge clk_i);
		start_i = 1'b0;
		i = 0;
		while (standby_o !== 1'b0 && i < 8) begin
			@(negedge clk_i);
			i++;
		end
		trig_i = 1'b0;
		t0 = cyc - 1;
		if (hw) cmpi(i, 2, "trigger start");
		else cmpi(t0, ts, "start edge");
	endtask : go

	// Stop, drain at full speed, expect standby and nothing pending
	task automatic halt();
		stop_i = 1'b1;
		@(negedge clk_i);
		stop_i = 1'b0;
		wt = 4'h0;
		repeat (40) @(negedge clk_i);
		cmpv(RES_W'(standby_o), 12'h001, "standby");
		cmpv(RES_W'(eoc_o), 12'h000, "eoc drained");
	endtask : halt

	initial begin
		int i;
		int n;
		int k;
		dsq_mode_t m;
		repeat (3) @(negedge clk_i);
		resetn_i = 1'b1;
		cmpv(result_o, 12'h000, "reset result");
		cmpv({eoc_o, done_o, standby_o}, 12'h001, "reset flags");
		// Single sample, 12-bit, slow reader
		wt = 4'h3 + 4'(rnd() % 8);
		go(MODE_SINGLE, 1'b0, 1'b1, 1'b0, DEC_HI);
		wait_rises(1, 5 * DEC_HI);
		cmpi(rises[0] - t0, 4 * DEC_HI + 2, "single latency");
		@(negedge clk_i);
		cmpv({eoc_o, done_o}, 12'h003, "eoc and done");
		k = n_took;
		repeat (40) @(negedge clk_i);
		cmpi(n_took - k, 1, "one read");
		cmpv({eoc_o, standby_o}, 12'h001, "back to standby");
		repeat (5 * DEC_HI) @(negedge clk_i);
		cmpi(rises.size(), 1, "idle in standby");
		cmpv(result_o, exp_word, "result held");
		clr_done = 1'b1;
		@(negedge clk_i);
		clr_done = 1'b0;
		@(negedge clk_i);
		cmpv(RES_W'(done_o), 12'h000, "done cleared");
		// Single sample, 8-bit, hardware trigger
		go(MODE_SINGLE, 1'b1, 1'b1, 1'b1, DEC_LO);
		wait_rises(1, 5 * DEC_LO);
		cmpi(rises[0] - t0, 4 * DEC_LO + 2, "fast latency");
		repeat (40) @(negedge clk_i);
		// Multi, turbo, continuous: first result and spacing
		for (int j = 0; j < 3; j++) begin
			m = ml[j];
			n = (m == MODE_MULTI) ? DEC_HI : DEC_LO;
			go(m, m == MODE_CONT, m[0], 1'b0, n);
			k = (m == MODE_CONT) ? n : 4 * n;
			wait_rises(4, 20 * n);
			cmpi(rises[0] - t0, 4 * n + 2, "first result");
			for (i = 1; i < 4; i++) begin
				cmpi(rises[i] - rises[i - 1], k, "gap");
			end
			if (m == MODE_TURBO) begin
				// Switch only in a turbo run, never in continuous
				// Lands in the second conversion, so one period is lost
				rises.delete();
				wait_rises(1, 5 * n);
				repeat (n + rnd() % (n - 4)) @(negedge clk_i);
				mux_sw = 1'b1;
				@(negedge clk_i);
				mux_sw = 1'b0;
				wait_rises(2, 8 * n);
				cmpi(rises[1] - rises[0], 5 * n, "switch gap");
			end
			if (m != MODE_CONT) halt();
		end
		// Stalled reader fills the buffer, then a burst drains it
		hold = 1'b1;
		repeat (12 * n) @(negedge clk_i);
		k = n_took;
		hold = 1'b0;
		wt = 4'h0;
		repeat (20) @(negedge clk_i);
		checked++;
		if (n_took - k < 9 || n_took - k > 10) err("buffer depth");
		halt();
		test_done();
	end
endmodule : testbench

`default_nettype wire
